// *** rtl/mplr_pkg.sv ***
// constants and types for the multilevel pipeline register
package mplr_pkg;
    localparam int width = 16;
    localparam int depth = 8;
    typedef logic [3:0] mplr_code_type;
    localparam mplr_code_type shift_chain_eight = 4'h8;
    localparam mplr_code_type shift_lower_four = 4'h9;
    localparam mplr_code_type shift_upper_four = 4'hA;
    localparam mplr_code_type shift_pair_first = 4'hB;
    localparam mplr_code_type shift_pair_second = 4'hC;
    localparam mplr_code_type shift_pair_third = 4'hD;
    localparam mplr_code_type shift_pair_fourth = 4'hE;
    localparam mplr_code_type hold_all = 4'hF;
    localparam int select_width = 3;
    localparam logic [15:0] output_reset_value = 16'h0000;
endpackage : mplr_pkg

// *** rtl/mplr_top.sv ***
// multilevel pipeline register: eight word registers, load/shift control, output mux
`timescale 1ns/1ps
module mplr_top (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [15:0] input_word,
    input wire logic [3:0] load_code,
    input wire logic [2:0] output_select,
    output logic [15:0] output_word
);
    logic [15:0] regs [0:7];
    logic [15:0] next_regs [0:7];
    logic [7:0] chain_mask;
    logic [7:0] head_mask;

    // =====================================================
    // load control decode
    always_comb begin
        chain_mask = 8'h00;
        head_mask = 8'h00;
        if (!load_code[3]) begin
            head_mask = 8'h01 << load_code[2:0];
            chain_mask = head_mask;
        end else begin
            unique case (load_code)
                mplr_pkg::shift_chain_eight: begin
                    chain_mask = 8'hFF;
                    head_mask = 8'h01;
                end
                mplr_pkg::shift_lower_four: begin
                    chain_mask = 8'h0F;
                    head_mask = 8'h01;
                end
                mplr_pkg::shift_upper_four: begin
                    chain_mask = 8'hF0;
                    head_mask = 8'h10;
                end
                mplr_pkg::shift_pair_first: begin
                    chain_mask = 8'h03;
                    head_mask = 8'h01;
                end
                mplr_pkg::shift_pair_second: begin
                    chain_mask = 8'h0C;
                    head_mask = 8'h04;
                end
                mplr_pkg::shift_pair_third: begin
                    chain_mask = 8'h30;
                    head_mask = 8'h10;
                end
                mplr_pkg::shift_pair_fourth: begin
                    chain_mask = 8'hC0;
                    head_mask = 8'h40;
                end
                mplr_pkg::hold_all: begin
                    chain_mask = 8'h00;
                    head_mask = 8'h00;
                end
                default: begin
                    chain_mask = 8'h00;
                    head_mask = 8'h00;
                end
            endcase
        end
    end

    // =====================================================
    // next register values
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            next_regs[i] = regs[i];
            if (chain_mask[i]) begin
                if (head_mask[i] || i == 0) begin
                    next_regs[i] = input_word;
                end else begin
                    next_regs[i] = regs[i-1];
                end
            end
        end
    end

    // storage has no reset: contents undefined until written
    always_ff @(posedge clk) begin
        for (int i = 0; i < 8; i++) begin
            regs[i] <= next_regs[i];
        end
    end

    // =====================================================
    // output register: select applied at the clock edge, so the word
    // seen is the one the selected register will hold after this edge
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            output_word <= mplr_pkg::output_reset_value;
        end else begin
            output_word <= next_regs[output_select];
        end
    end

    // =====================================================
    // assertions: loads, holds and mux
    a_single_load: assert property (@(posedge clk) disable iff (!resetn)
        !load_code[3] && load_code[2:0] == output_select |=> output_word == $past(input_word))
        else $error("single load not seen on output");
    a_hold_all: assert property (@(posedge clk) disable iff (!resetn)
        load_code == mplr_pkg::hold_all ##1 load_code == mplr_pkg::hold_all && $stable(output_select)
        |=> $stable(output_word))
        else $error("hold changed output");
    a_select_mux: assert property (@(posedge clk) disable iff (!resetn)
        load_code == mplr_pkg::hold_all |=> output_word == $past(regs[output_select]))
        else $error("output mux mismatch");
    a_single_leaves: assert property (@(posedge clk) disable iff (!resetn)
        load_code == mplr_pkg::hold_all && output_select == 3'h1 ##1
        load_code == 4'h0 && output_select == 3'h1
        |=> $stable(output_word))
        else $error("single load touched other register");

    // =====================================================
    // assertions: chain shifts
    a_eight_shift: assert property (@(posedge clk) disable iff (!resetn)
        load_code == mplr_pkg::shift_chain_eight && output_select == 3'h0 ##1
        load_code == mplr_pkg::shift_chain_eight && output_select == 3'h1
        |=> output_word == $past(input_word, 2))
        else $error("eight chain shift wrong");
    // a word seen in one register moves on to the next
    a_eight_mid: assert property (@(posedge clk) disable iff (!resetn)
        load_code == mplr_pkg::shift_chain_eight && output_select == 3'h3 ##1
        load_code == mplr_pkg::shift_chain_eight && output_select == 3'h4
        |=> output_word == $past(output_word))
        else $error("eight chain middle shift wrong");
    a_eight_tail: assert property (@(posedge clk) disable iff (!resetn)
        load_code == mplr_pkg::shift_chain_eight && output_select == 3'h6 ##1
        load_code == mplr_pkg::shift_chain_eight && output_select == 3'h7
        |=> output_word == $past(output_word))
        else $error("eight chain tail shift wrong");
    a_lower_shift: assert property (@(posedge clk) disable iff (!resetn)
        load_code == mplr_pkg::shift_lower_four && output_select == 3'h0 ##1
        load_code == mplr_pkg::shift_lower_four && output_select == 3'h1
        |=> output_word == $past(input_word, 2))
        else $error("lower chain shift wrong");
    a_lower_tail: assert property (@(posedge clk) disable iff (!resetn)
        load_code == mplr_pkg::shift_lower_four && output_select == 3'h2 ##1
        load_code == mplr_pkg::shift_lower_four && output_select == 3'h3
        |=> output_word == $past(output_word))
        else $error("lower chain tail wrong");
    a_upper_head: assert property (@(posedge clk) disable iff (!resetn)
        load_code == mplr_pkg::shift_upper_four && output_select == 3'h4 |=> output_word == $past(input_word))
        else $error("upper chain head wrong");
    a_upper_shift: assert property (@(posedge clk) disable iff (!resetn)
        load_code == mplr_pkg::shift_upper_four && output_select == 3'h4 ##1
        load_code == mplr_pkg::shift_upper_four && output_select == 3'h5
        |=> output_word == $past(input_word, 2))
        else $error("upper chain shift wrong");
    a_upper_tail: assert property (@(posedge clk) disable iff (!resetn)
        load_code == mplr_pkg::shift_upper_four && output_select == 3'h6 ##1
        load_code == mplr_pkg::shift_upper_four && output_select == 3'h7
        |=> output_word == $past(output_word))
        else $error("upper chain tail wrong");
    a_pair_first: assert property (@(posedge clk) disable iff (!resetn)
        load_code == mplr_pkg::shift_pair_first && output_select == 3'h0 ##1
        load_code == mplr_pkg::shift_pair_first && output_select == 3'h1
        |=> output_word == $past(input_word, 2))
        else $error("first pair shift wrong");
    a_pair_second: assert property (@(posedge clk) disable iff (!resetn)
        load_code == mplr_pkg::shift_pair_second && output_select == 3'h2 ##1
        load_code == mplr_pkg::shift_pair_second && output_select == 3'h3
        |=> output_word == $past(input_word, 2))
        else $error("second pair shift wrong");
    a_pair_third: assert property (@(posedge clk) disable iff (!resetn)
        load_code == mplr_pkg::shift_pair_third && output_select == 3'h4 ##1
        load_code == mplr_pkg::shift_pair_third && output_select == 3'h5
        |=> output_word == $past(input_word, 2))
        else $error("third pair shift wrong");
    a_pair_shift: assert property (@(posedge clk) disable iff (!resetn)
        load_code == mplr_pkg::shift_pair_fourth && output_select == 3'h6 ##1
        load_code == mplr_pkg::shift_pair_fourth && output_select == 3'h7
        |=> output_word == $past(input_word, 2))
        else $error("pair shift wrong");

    // =====================================================
    // assertions: untouched registers
    // hold first so the watched register is settled
    a_lower_leaves: assert property (@(posedge clk) disable iff (!resetn)
        load_code == mplr_pkg::hold_all && output_select == 3'h5 ##1
        load_code == mplr_pkg::shift_lower_four && output_select == 3'h5
        |=> $stable(output_word))
        else $error("lower chain touched upper register");
    a_upper_leaves: assert property (@(posedge clk) disable iff (!resetn)
        load_code == mplr_pkg::hold_all && output_select == 3'h0 ##1
        load_code == mplr_pkg::shift_upper_four && output_select == 3'h0
        |=> $stable(output_word))
        else $error("upper chain touched lower register");
    a_first_leaves: assert property (@(posedge clk) disable iff (!resetn)
        load_code == mplr_pkg::hold_all && output_select == 3'h2 ##1
        load_code == mplr_pkg::shift_pair_first && output_select == 3'h2
        |=> $stable(output_word))
        else $error("first pair touched other register");
    a_pair_keep: assert property (@(posedge clk) disable iff (!resetn)
        load_code == mplr_pkg::hold_all && output_select == 3'h0 ##1
        load_code == mplr_pkg::shift_pair_second && output_select == 3'h0
        |=> $stable(output_word))
        else $error("pair shift touched other register");
    a_second_leaves: assert property (@(posedge clk) disable iff (!resetn)
        load_code == mplr_pkg::hold_all && output_select == 3'h4 ##1
        load_code == mplr_pkg::shift_pair_second && output_select == 3'h4
        |=> $stable(output_word))
        else $error("second pair touched other register");
    a_third_leaves: assert property (@(posedge clk) disable iff (!resetn)
        load_code == mplr_pkg::hold_all && output_select == 3'h0 ##1
        load_code == mplr_pkg::shift_pair_third && output_select == 3'h0
        |=> $stable(output_word))
        else $error("third pair touched other register");
    a_fourth_leaves: assert property (@(posedge clk) disable iff (!resetn)
        load_code == mplr_pkg::hold_all && output_select == 3'h4 ##1
        load_code == mplr_pkg::shift_pair_fourth && output_select == 3'h4
        |=> $stable(output_word))
        else $error("fourth pair touched other register");

    // =====================================================
    // assertions: reset and covers
    // only the output flop is reset
    a_reset_output: assert property (@(posedge clk)
        !resetn ##1 !resetn |-> output_word == mplr_pkg::output_reset_value)
        else $error("output not cleared in reset");
    c_eight_shift: cover property (@(posedge clk) load_code == mplr_pkg::shift_chain_eight [*8]);
    c_single: cover property (@(posedge clk) !load_code[3] ##1 load_code == mplr_pkg::hold_all);
    c_reconfig: cover property (@(posedge clk) load_code == mplr_pkg::shift_chain_eight ##1 load_code == 4'h0);
    c_lower_shift: cover property (@(posedge clk) load_code == mplr_pkg::shift_lower_four [*2]);
    c_hold_pair: cover property (@(posedge clk) load_code == mplr_pkg::hold_all [*2]);
endmodule : mplr_top

// *** verif/mplr_ctrl.sv ***
// controller model driving load codes, data and output select
`timescale 1ns/1ps
module mplr_ctrl (
    input wire logic clk,
    input wire logic run,
    output logic [15:0] input_word,
    output logic [3:0] load_code,
    output logic [2:0] output_select
);
    // directed {load code, select} pairs aimed at every chain and hold
    localparam logic [6:0] plan [43] = '{
        7'h40, 7'h41, 7'h42, 7'h43, 7'h44, 7'h45, 7'h46, 7'h47,
        7'h00, 7'h79, 7'h01, 7'h7D, 7'h4D, 7'h48, 7'h49, 7'h4A, 7'h4B,
        7'h78, 7'h50, 7'h54, 7'h55, 7'h56, 7'h57, 7'h78, 7'h60,
        7'h7A, 7'h5A, 7'h58, 7'h59, 7'h7C, 7'h64, 7'h62, 7'h63,
        7'h78, 7'h68, 7'h6C, 7'h6D, 7'h7C, 7'h74, 7'h76, 7'h77, 7'h7A, 7'h7A};
    int step = 0;
    initial begin
        input_word = 16'h0000;
        load_code = mplr_pkg::hold_all;
        output_select = 3'h0;
    end
    // first eight ops fill a..h, then any code back to back
    always @(negedge clk) begin
        if (run) begin
            if (step == 0) begin
                void'($urandom(41));
            end
            input_word <= 16'($urandom);
            if (step < 8) begin
                load_code <= 4'(step);
                output_select <= 3'($urandom);
            end else if (step < 51) begin
                {load_code, output_select} <= plan[step-8];
            end else begin
                load_code <= 4'($urandom);
                output_select <= 3'($urandom);
            end
            step <= step + 1;
        end else begin
            load_code <= mplr_pkg::hold_all;
        end
    end
endmodule : mplr_ctrl

// *** verif/testbench.sv ***
// self-checking bench comparing the register file with a behavioural model
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic run = 1'b0;
    logic [15:0] input_word;
    logic [3:0] load_code;
    logic [2:0] output_select;
    logic [15:0] output_word;
    int bad_count = 0;
    int n_compared = 0;
    logic [15:0] m [8];
    logic [7:0] ok = 8'h00;
    int sel_q, lo, hi;
    bit cmp = 1'b0;
    logic [15:0] tail_word;
    logic [15:0] tail_want = 16'h0000;
    bit tail_cmp = 1'b0;
    mplr_ctrl ctrl (.clk(clk), .run(run), .input_word(input_word), .load_code(load_code),
        .output_select(output_select));
    mplr_top uut (.clk(clk), .resetn(resetn), .input_word(input_word), .load_code(load_code),
        .output_select(output_select), .output_word(output_word));
    // second device in depth, always loading its first register
    mplr_top uut_tail (.clk(clk), .resetn(resetn), .input_word(output_word), .load_code(4'h0),
        .output_select(3'h0), .output_word(tail_word));
    initial forever #50 clk = ~clk;
    task check(input logic [15:0] seen, input logic [15:0] want);
        n_compared++;
        if (seen !== want) begin
            bad_count++;
            $display("CHECK FAILED at %0t: output word mismatch", $time);
        end
    endtask : check
    task print_verdict;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : print_verdict
    // model: chain from lo to hi shifts, input enters lo
    always @(posedge clk) begin
        if (run) begin
            lo = load_code[3] ? 0 : int'(load_code[2:0]);
            hi = lo;
            case (load_code)
                4'h8: hi = 7;
                4'h9: hi = 3;
                4'hA: begin lo = 4; hi = 7; end
                4'hB: hi = 1;
                4'hC: begin lo = 2; hi = 3; end
                4'hD: begin lo = 4; hi = 5; end
                4'hE: begin lo = 6; hi = 7; end
                4'hF: hi = -1;
                default: ;
            endcase
            for (int i = hi; i > lo; i--) begin
                m[i] = m[i-1];
                ok[i] = ok[i-1];
            end
            if (hi >= lo) begin
                m[lo] = input_word;
                ok[lo] = 1'b1;
            end
            sel_q = output_select;
            cmp = ok[sel_q];
        end
    end
    // unwritten registers read undefined, so only written ones compare
    always @(negedge clk) begin
        if (!resetn) begin
            check(output_word, mplr_pkg::output_reset_value);
            check(tail_word, mplr_pkg::output_reset_value);
            tail_want = mplr_pkg::output_reset_value;
            tail_cmp = 1'b1;
        end else begin
            if (tail_cmp) check(tail_word, tail_want);
            if (cmp) check(output_word, m[sel_q]);
            tail_want = m[sel_q];
            tail_cmp = cmp;
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        @(negedge clk);
        run <= 1'b1;
        @(negedge clk);
        resetn <= 1'b1;
        repeat (800) @(posedge clk);
        @(negedge clk);
        $display("test random_ops done");
        resetn <= 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        resetn <= 1'b1;
        repeat (20) @(posedge clk);
        @(negedge clk);
        $display("test reset_midrun done");
        print_verdict();
    end
    initial begin
        #(100 * 2000);
        bad_count++;
        print_verdict();
    end
endmodule : testbench
